//--- rtl/pds_synth_core.sv
// serial programming, dividers and phase detector of the synthesizer
`timescale 1ns/1ps
// What this block does
// R1: reference ratio 14 bits, 3 to 16383
// R2: host never programs reference ratio below 3
// R3: control bit high loads reference, prescaler latches
// R4: control bit low loads swallow, programmable latches
// R5: prescaler bit zero picks larger modulus pair
// R6: swallow ratio 7 bits, 0 to 127
// R7: programmable ratio 11 bits, 3 to 2047
// R8: host keeps swallow count not above programmable
// R9: feedback divides by P times B plus A
// R10: data sampled on serial clock rising edge
// R11: host shifts MSB first, control bit last
// R12: polarity pin inverts the phase detector
// R13: polarity selects which divider is monitored
// R14: load enable high routes pump to switch
// R15: locked loop gives minimum-width pump pulses
// R16: word commits on load enable rise, full
module pds_synth_core
   import pds_pkg::*;
#(
   parameter bit FAST_PRESCALER = 1'b0
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // serial programming pins
   input wire logic ser_data_in,
   input wire logic ser_clk_in,
   input wire logic load_enable_pin_in,
   // configuration pin, high when left open
   input wire logic phase_polarity_pin_in,
   // reference and vco pulse inputs
   input wire logic osc_in,
   input wire logic vco_in,
   // phase detector pump outputs
   output logic pump_up_out,
   output logic pump_down_out,
   output logic charge_pump_output_out,
   output logic charge_pump_output_oe_out,
   // scanning filter switch
   output logic filter_switch_pin_out,
   output logic filter_switch_pin_oe_out,
   // divider monitor
   output logic divider_monitor_output_out
);
   // ==========================================================
   // pin synchronisers
   localparam int NP = 6;
   logic [NP-1:0] pin_raw, sync1, sync2, sync3;
   logic sdat, sclk_rise, le_s, le_rise, pol_s, osc_rise, vco_rise;
   assign pin_raw = {vco_in, osc_in, phase_polarity_pin_in,
                     load_enable_pin_in, ser_clk_in, ser_data_in};

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign sdat = sync2[0];
   assign sclk_rise = sync2[1] & ~sync3[1];
   assign le_s = sync2[2];
   assign le_rise = sync2[2] & ~sync3[2];
   assign pol_s = sync2[3];
   assign osc_rise = sync2[4] & ~sync3[4];
   assign vco_rise = sync2[5] & ~sync3[5];

   // ==========================================================
   // shift register and latches
   logic [WORD_W-1:0] shift_reg, next_shift_reg;
   logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
   logic commit, presc_sel, next_presc_sel;
   logic [REF_W-1:0] ref_ratio, next_ref_ratio, ref_eff;
   logic [SWAL_W-1:0] swal_ratio, next_swal_ratio;
   logic [PROG_W-1:0] prog_ratio, next_prog_ratio;
   assign commit = le_rise && (bit_cnt == BIT_CNT_FULL); // R16

   always_comb begin
      next_shift_reg = shift_reg;
      next_bit_cnt = bit_cnt;
      next_ref_ratio = ref_ratio;
      next_presc_sel = presc_sel;
      next_swal_ratio = swal_ratio;
      next_prog_ratio = prog_ratio;
      if (sclk_rise) begin
         next_shift_reg = {shift_reg[WORD_W-2:0], sdat}; // R10
         if (bit_cnt != BIT_CNT_FULL) begin
            next_bit_cnt = bit_cnt + CNT_W'(1);
         end
      end
      if (le_rise) begin
         next_bit_cnt = '0;
      end
      if (commit && shift_reg[CTRL_POS]) begin
         next_ref_ratio = shift_reg[REF_LSB +: REF_W]; // R3
         next_presc_sel = shift_reg[PSEL_POS]; // R3
      end else if (commit) begin
         next_swal_ratio = shift_reg[SWAL_LSB +: SWAL_W]; // R4 R6
         next_prog_ratio = shift_reg[PROG_LSB +: PROG_W]; // R4
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         shift_reg <= '0;
         bit_cnt <= '0;
         ref_ratio <= REF_RST;
         presc_sel <= PSEL_RST;
         swal_ratio <= SWAL_RST;
         prog_ratio <= PROG_RST;
      end else begin
         shift_reg <= next_shift_reg;
         bit_cnt <= next_bit_cnt;
         ref_ratio <= next_ref_ratio;
         presc_sel <= next_presc_sel;
         swal_ratio <= next_swal_ratio;
         prog_ratio <= next_prog_ratio;
      end
   end

   // ==========================================================
   // reference divider
   logic ref_tick;
   // forbidden low ratios act as the minimum
   assign ref_eff = (ref_ratio < REF_MIN) ? REF_MIN : ref_ratio; // R1

   pds_divider #(.W(REF_W)) u_ref_div (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .tick_in(osc_rise),
      .ratio_in(ref_eff),
      .term_out(ref_tick)
   );

   // ==========================================================
   // pulse-swallow feedback divider
   logic [PRE_W-1:0] pre_base, pre_mod, pre_cnt, next_pre_cnt;
   logic [PROG_W-1:0] prog_eff, b_cnt, next_b_cnt;
   logic [SWAL_W-1:0] a_left, next_a_left;
   logic fb_tick, next_fb_tick;
   assign pre_base = presc_sel ?
      (FAST_PRESCALER ? PRE_SMALL_FAST : PRE_SMALL_STD) : // R5
      (FAST_PRESCALER ? PRE_LARGE_FAST : PRE_LARGE_STD); // R5
   // swallow periods run at P+1
   assign pre_mod = pre_base + PRE_W'(a_left != '0); // R9
   assign prog_eff = (prog_ratio < PROG_MIN) ? PROG_MIN : prog_ratio; // R7

   always_comb begin
      next_pre_cnt = pre_cnt;
      next_b_cnt = b_cnt;
      next_a_left = a_left;
      next_fb_tick = 1'b0;
      if (vco_rise) begin
         if (pre_cnt == pre_mod - PRE_W'(1)) begin
            next_pre_cnt = '0;
            if (b_cnt == '0) begin
               next_b_cnt = prog_eff - PROG_W'(1); // R9
               next_a_left = swal_ratio; // R9
               next_fb_tick = 1'b1;
            end else begin
               next_b_cnt = b_cnt - PROG_W'(1);
               if (a_left != '0) begin
                  next_a_left = a_left - SWAL_W'(1);
               end
            end
         end else begin
            next_pre_cnt = pre_cnt + PRE_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pre_cnt <= '0;
         b_cnt <= '0;
         a_left <= '0;
         fb_tick <= 1'b0;
      end else begin
         pre_cnt <= next_pre_cnt;
         b_cnt <= next_b_cnt;
         a_left <= next_a_left;
         fb_tick <= next_fb_tick;
      end
   end

   // ==========================================================
   // phase detector and outputs
   pds_pd_state_t pd_state, next_pd_state;
   logic lead, lag, next_up, next_dn;
   always_comb begin
      next_pd_state = pd_state;
      case (pd_state)
         PD_IDLE: begin
            if (ref_tick && fb_tick) begin
               next_pd_state = PD_BOTH; // R15
            end else if (ref_tick) begin
               next_pd_state = PD_UP;
            end else if (fb_tick) begin
               next_pd_state = PD_DN;
            end
         end
         PD_UP: begin
            if (fb_tick) begin
               next_pd_state = PD_BOTH;
            end
         end
         PD_DN: begin
            if (ref_tick) begin
               next_pd_state = PD_BOTH;
            end
         end
         PD_BOTH: begin
            next_pd_state = PD_IDLE; // R15
         end
         default: begin
            next_pd_state = PD_IDLE;
         end
      endcase
      lead = (next_pd_state == PD_UP) || (next_pd_state == PD_BOTH);
      lag = (next_pd_state == PD_DN) || (next_pd_state == PD_BOTH);
      next_up = pol_s ? lead : lag; // R12
      next_dn = pol_s ? lag : lead; // R12
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pd_state <= PD_IDLE;
         pump_up_out <= 1'b0;
         pump_down_out <= 1'b0;
         charge_pump_output_out <= 1'b0;
         charge_pump_output_oe_out <= 1'b0;
         filter_switch_pin_out <= 1'b0;
         filter_switch_pin_oe_out <= 1'b0;
         divider_monitor_output_out <= 1'b0;
      end else begin
         pd_state <= next_pd_state;
         pump_up_out <= next_up;
         pump_down_out <= next_dn;
         charge_pump_output_out <= next_up;
         charge_pump_output_oe_out <= next_up | next_dn;
         filter_switch_pin_out <= next_up; // R14
         filter_switch_pin_oe_out <= le_s & (next_up | next_dn); // R14
         divider_monitor_output_out <= pol_s ? ref_tick : fb_tick; // R13
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   a_ref_latch_load: assert property ( // R3
      commit && shift_reg[CTRL_POS] |=>
      (ref_ratio == $past(shift_reg[REF_LSB +: REF_W])) &&
      (presc_sel == $past(shift_reg[PSEL_POS])))
      else $error("reference latches not loaded");
   a_cnt_latch_load: assert property ( // R4
      commit && !shift_reg[CTRL_POS] |=>
      (swal_ratio == $past(shift_reg[SWAL_LSB +: SWAL_W])) &&
      (prog_ratio == $past(shift_reg[PROG_LSB +: PROG_W])))
      else $error("counter latches not loaded");
   a_no_early_commit: assert property ( // R16
      !commit |=> $stable(ref_ratio) && $stable(prog_ratio) &&
      $stable(swal_ratio) && $stable(presc_sel))
      else $error("latch changed without a full word");
   a_shift_on_rise: assert property ( // R10
      sclk_rise |=> shift_reg ==
      {$past(shift_reg[WORD_W-2:0]), $past(sdat)})
      else $error("serial bit not shifted on clock rise");
   a_modulus_pick: assert property ( // R5
      (a_left == '0) && !presc_sel |->
      pre_mod == (FAST_PRESCALER ? PRE_LARGE_FAST : PRE_LARGE_STD))
      else $error("wrong prescaler modulus");
   a_ratio_floor: assert property ( // R1 R7
      (ref_eff >= REF_MIN) && (prog_eff >= PROG_MIN) &&
      ((ref_ratio < REF_MIN) || (ref_eff == ref_ratio)))
      else $error("divider ratio below minimum");
   a_monitor_select: assert property ( // R13
      (pol_s ? ref_tick : fb_tick) |=> divider_monitor_output_out)
      else $error("monitor missed divider pulse");
   a_pump_polarity: assert property ( // R12
      pd_state == PD_UP |->
      (pump_up_out == $past(pol_s)) && (pump_down_out != $past(pol_s)))
      else $error("pump polarity wrong");
   a_min_width: assert property ( // R15
      pd_state == PD_BOTH |=> (pd_state == PD_IDLE) &&
      !pump_up_out && !pump_down_out)
      else $error("locked pump pulse not minimum width");
   a_switch_follows: assert property ( // R14
      le_s ##1 charge_pump_output_oe_out |->
      filter_switch_pin_oe_out &&
      (filter_switch_pin_out == charge_pump_output_out))
      else $error("switch pin not following pump");

   c_ref_commit: cover property (commit && shift_reg[CTRL_POS]);
   c_cnt_commit: cover property (commit && !shift_reg[CTRL_POS]);
   c_locked: cover property (pd_state == PD_BOTH);
   c_switch: cover property (filter_switch_pin_oe_out);
endmodule : pds_synth_core

//--- rtl/pds_pkg.sv
// constants and types shared by the synthesizer programming logic
package pds_pkg;
   // ==========================================================
   // serial word layout, bit 0 is the last bit shifted in
   localparam int WORD_W = 19;
   localparam int REF_W = 14;
   localparam int SWAL_W = 7;
   localparam int PROG_W = 11;
   localparam int PRE_W = 8;
   localparam int CNT_W = 5;
   localparam int CTRL_POS = 0;
   localparam int REF_LSB = 1;
   localparam int PSEL_POS = 15;
   localparam int SWAL_LSB = 1;
   localparam int PROG_LSB = 8;
   localparam logic [CNT_W-1:0] BIT_CNT_FULL = 5'h13;
   // ==========================================================
   // ratio limits and reset values
   localparam logic [REF_W-1:0] REF_MIN = 14'h0003;
   localparam logic [REF_W-1:0] REF_RST = 14'h0003;
   localparam logic [PROG_W-1:0] PROG_MIN = 11'h003;
   localparam logic [PROG_W-1:0] PROG_RST = 11'h003;
   localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
   localparam logic PSEL_RST = 1'b0;
   // ==========================================================
   // dual-modulus prescaler base moduli
   localparam logic [PRE_W-1:0] PRE_LARGE_STD = 8'h80;
   localparam logic [PRE_W-1:0] PRE_SMALL_STD = 8'h40;
   localparam logic [PRE_W-1:0] PRE_LARGE_FAST = 8'h40;
   localparam logic [PRE_W-1:0] PRE_SMALL_FAST = 8'h20;
   // ==========================================================
   // phase detector states
   typedef enum logic [1:0] {
      PD_IDLE = 2'b00,
      PD_UP = 2'b01,
      PD_BOTH = 2'b11,
      PD_DN = 2'b10
   } pds_pd_state_t;
endpackage : pds_pkg

//--- rtl/pds_divider.sv
// down-counting programmable divider with a one-cycle terminal pulse
`timescale 1ns/1ps
module pds_divider #(
   parameter int W = 14
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // count input and ratio
   input wire logic tick_in,
   input wire logic [W-1:0] ratio_in,
   // divided output
   output logic term_out
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_term;

   always_comb begin
      next_cnt = cnt;
      next_term = 1'b0;
      if (tick_in) begin
         if (cnt == '0) begin
            next_cnt = ratio_in - W'(1);
            next_term = 1'b1;
         end else begin
            next_cnt = cnt - W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cnt <= '0;
         term_out <= 1'b0;
      end else begin
         cnt <= next_cnt;
         term_out <= next_term;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   a_term_cause: assert property ( // R9
      term_out |-> $past(tick_in) && ($past(cnt) == '0))
      else $error("divider pulse without terminal count");
   a_reload_ratio: assert property ( // R9
      tick_in && (cnt == '0) |=> cnt == $past(ratio_in) - W'(1))
      else $error("divider did not reload its ratio");
endmodule : pds_divider

//--- dv/pds_host_model.sv
// host controller model driving the three-wire programming link
`timescale 1ns/1ps
module pds_host_model (
   // system clock for pacing
   input wire logic sys_clk_in,
   // serial programming pins
   output logic ser_data_out,
   output logic ser_clk_out,
   output logic load_enable_pin_out
);
   initial begin
      ser_data_out = 1'b0;
      ser_clk_out = 1'b0;
      load_enable_pin_out = 1'b0;
   end

   // ==========================================================
   // word transfer, link clock of 8 system cycles
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #2;
   endtask : wait_cyc

   task automatic send(input logic [18:0] w, input int n, input int le_cyc);
      wait_cyc(1);
      for (int i = n - 1; i >= 0; i--) begin
         ser_data_out = w[i];
         ser_clk_out = 1'b0;
         wait_cyc(4);
         ser_clk_out = 1'b1;
         wait_cyc(4);
      end
      // clock stands still, released data shows no stale bit
      ser_clk_out = 1'b0;
      ser_data_out = ~ser_data_out;
      wait_cyc(4);
      load_enable_pin_out = 1'b1;
      wait_cyc(le_cyc);
      load_enable_pin_out = 1'b0;
      wait_cyc(4);
   endtask : send
endmodule : pds_host_model

//--- dv/pds_synth_core_tb.sv
// self-checking bench for the synthesizer programming logic
`timescale 1ns/1ps
module pds_synth_core_tb;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ser_data, ser_clk, le_pin;
   logic pol = 1'b1;
   logic osc_in = 1'b0;
   logic vco_in = 1'b0;
   logic osc_en = 1'b1;
   logic vco_en = 1'b1;
   logic [1:0] ph = 2'h0;
   logic [4:0] le_hist = 5'h00;
   logic pump_up, pump_dn, cp_out, cp_oe, sw_out, sw_oe, mon;
   int miscompares = 0;
   int tests_run = 0;
   int sw_on = 0;
   int sw_bad = 0;

   initial begin
      forever #25 sys_clk_in = ~sys_clk_in;
   end

   pds_host_model pds_host_model_inst (
      .sys_clk_in(sys_clk_in),
      .ser_data_out(ser_data),
      .ser_clk_out(ser_clk),
      .load_enable_pin_out(le_pin)
   );

   pds_synth_core pds_synth_core_inst (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .ser_data_in(ser_data),
      .ser_clk_in(ser_clk),
      .load_enable_pin_in(le_pin),
      .phase_polarity_pin_in(pol),
      .osc_in(osc_in),
      .vco_in(vco_in),
      .pump_up_out(pump_up),
      .pump_down_out(pump_dn),
      .charge_pump_output_out(cp_out),
      .charge_pump_output_oe_out(cp_oe),
      .filter_switch_pin_out(sw_out),
      .filter_switch_pin_oe_out(sw_oe),
      .divider_monitor_output_out(mon)
   );

   // ==========================================================
   // oscillator and vco pulses, one rising edge every 4 cycles
   always @(posedge sys_clk_in) begin
      ph <= ph + 2'h1;
      osc_in <= #2 osc_en & ph[1];
      vco_in <= #2 vco_en & ph[1];
      le_hist <= {le_hist[3:0], le_pin};
      if (!rst_in && le_pin && sw_oe === 1'b1) begin
         sw_on++;
      end
      if (!rst_in && !le_pin && le_hist === 5'h00 && sw_oe !== 1'b0) begin
         sw_bad++;
      end
      // switch pin must carry the pump value while enabled
      if (!rst_in && sw_oe === 1'b1 && sw_out !== cp_out) begin
         sw_bad++;
      end
   end

   // ==========================================================
   // compare, measure and closing tasks
   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk

   task automatic period(input string name, input int exp);
      int k;
      int n;
      k = 0;
      n = 1;
      repeat (8) @(negedge sys_clk_in);
      while (mon !== 1'b1 && k < 70000) begin
         @(negedge sys_clk_in);
         k++;
      end
      @(negedge sys_clk_in);
      while (mon !== 1'b1 && n < 70000) begin
         @(negedge sys_clk_in);
         n++;
      end
      chk(name, exp, n);
   endtask : period

   task automatic final_report;
      if (miscompares == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge sys_clk_in);
      miscompares++;
      final_report();
   end

   // ==========================================================
   // test sequence
   initial begin
      repeat (16) @(posedge sys_clk_in);
      #2;
      rst_in = 1'b0;
      period("ref_reset", 4 * 3);
      pds_host_model_inst.send({3'h0, 1'b1, 14'h0007, 1'b1}, 19, 8);
      period("ref_seven", 4 * 7);
      @(posedge sys_clk_in);
      #2 pol = 1'b0;
      pds_host_model_inst.send({11'h003, 7'h02, 1'b0}, 19, 8);
      period("fb_small_mod", 4 * (64 * 3 + 2));
      pds_host_model_inst.send({3'h0, 1'b0, 14'h0007, 1'b1}, 19, 8);
      period("fb_large_mod", 4 * (128 * 3 + 2));
      pds_host_model_inst.send({11'h005, 7'h01, 1'b0}, 18, 8);
      period("short_word", 4 * (128 * 3 + 2));
      pds_host_model_inst.send({3'h0, 1'b1, 14'h0007, 1'b1}, 19, 8);
      pds_host_model_inst.send({11'h07F, 7'h7F, 1'b0}, 19, 8);
      period("fb_max_a", 4 * (64 * 127 + 127));
      @(posedge sys_clk_in);
      #2 pol = 1'b1;
      vco_en = 1'b0;
      repeat (200) @(negedge sys_clk_in);
      chk("pump_up", 1, pump_up);
      chk("pump_down", 0, pump_dn);
      chk("pump_pin", 1, cp_out);
      chk("pump_pin_oe", 1, cp_oe);
      @(posedge sys_clk_in);
      #2 pol = 1'b0;
      repeat (200) @(negedge sys_clk_in);
      chk("pump_up_inv", 0, pump_up);
      chk("pump_down_inv", 1, pump_dn);
      chk("pump_pin_inv", 0, cp_out);
      pds_host_model_inst.send({3'h0, 1'b1, 14'h0007, 1'b1}, 19, 20);
      chk("switch_on", 1, sw_on > 8);
      chk("switch_off", 0, sw_bad);
      @(posedge sys_clk_in);
      #2 pol = 1'b1;
      period("monitor_ref", 4 * 7);
      final_report();
   end
endmodule : pds_synth_core_tb
